// File: rtl/mtal_pkg.sv
/*
 * Constants for the access-log and error-response responder.
 * Assumes query fields arrive already decoded by the server front end.
 */
package mtal_pkg;

	// ------------------------------------------------------------
	// function codes handled here
	// ------------------------------------------------------------
	localparam logic [7:0] MTAL_FC_READ = 8'h03;
	localparam logic [7:0] MTAL_FC_WRITE1 = 8'h06;
	localparam logic [7:0] MTAL_FC_WRITEN = 8'h10;
	localparam logic [7:0] MTAL_FC_LOG = 8'h46;
	localparam logic [7:0] MTAL_FC_EXC_FLAG = 8'h80;

	// ------------------------------------------------------------
	// exception codes
	// ------------------------------------------------------------
	localparam logic [7:0] MTAL_EX_FUNC = 8'h01;
	localparam logic [7:0] MTAL_EX_ADDR = 8'h02;
	localparam logic [7:0] MTAL_EX_DATA = 8'h03;
	localparam logic [7:0] MTAL_EX_BUSY = 8'h06;

	// ------------------------------------------------------------
	// header constants and frame sizes
	// ------------------------------------------------------------
	localparam logic [15:0] MTAL_PROTO_ID = 16'h0000;
	localparam logic [7:0] MTAL_UNIT_ID = 8'hFF;
	localparam logic [15:0] MTAL_LOG_LEN = 16'h0006;
	localparam logic [15:0] MTAL_EXC_LEN = 16'h0003;
	localparam logic [3:0] MTAL_LOG_BYTES = 4'hC;
	localparam logic [3:0] MTAL_EXC_BYTES = 4'h9;
	localparam logic [15:0] MTAL_LOG_RESET = 16'h0000;
	localparam logic [23:0] MTAL_PAD = 24'h000000;

	// ------------------------------------------------------------
	// responder states
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		MTAL_IDLE = 2'b00,
		MTAL_SEND = 2'b01
	} mtal_state_t;

endpackage : mtal_pkg

// File: rtl/mtal_responder.sv
/*
 * Access-log reply and exception-response generator of a Modbus/TCP
 * slave, plus the per-register zero/discard gate for block access.
 * Assumes the front end presents one decoded query at a time with
 * its accessibility counts, and drains response bytes with tx_ready.
 */
// Overview of operation
// - H46 returns previous successful start and count
// - log entries only for H03, H06, H10
// - other previous codes log zero start, count
// - logged start is register number minus 40001
// - 16-bit count follows start in H46 reply
// - transaction identifier copied unchanged into response
// - nonzero protocol id gets no reply; send zero
// - length counts unit id through data end
// - bad function, address or data gets exception
// - exception function code is request plus H80
// - codes 01 function, 02 address, 03 data
// - busy slave answers exception code 06
// - range or mode is 03; missing register 02
// - H03/H10 no error while one register accessible
// - exception when no addressed register exists
// - missing register reads zero, writes discarded
`timescale 1ns/1ps

module mtal_responder
	import mtal_pkg::*;
(
	input wire logic clk,
	input wire logic resetn,
	input wire logic q_valid,
	output logic q_ready,
	input wire logic [15:0] q_tid,
	input wire logic [15:0] q_pid,
	input wire logic [7:0] q_unit,
	input wire logic [7:0] q_func,
	input wire logic [15:0] q_start,
	input wire logic [15:0] q_qty,
	input wire logic [15:0] q_exist_cnt,
	input wire logic [15:0] q_ok_cnt,
	input wire logic q_data_bad,
	input wire logic drive_busy,
	output logic fwd_valid,
	output logic tx_valid,
	input wire logic tx_ready,
	output logic [7:0] tx_data,
	output logic tx_last,
	output logic [15:0] log_start,
	output logic [15:0] log_count,
	input wire logic rd_req,
	input wire logic rd_exist,
	input wire logic [15:0] rd_word,
	output logic rd_valid,
	output logic [15:0] rd_data,
	input wire logic wr_req,
	input wire logic wr_exist,
	input wire logic [15:0] wr_word,
	output logic wr_en,
	output logic [15:0] wr_data
);

	// ------------------------------------------------------------
	// query classification
	// ------------------------------------------------------------
	mtal_state_t state_q;
	logic take;
	logic hdr_ok;
	logic is_reg;
	logic is_multi;
	logic unsup;
	logic addr_bad;
	logic data_bad;
	logic exc;
	logic [7:0] exc_code;
	logic [95:0] frame_q;
	logic [3:0] left_q;

	// a query is taken only while idle
	assign take = q_valid && q_ready;
	// foreign protocol id or unit id: silently dropped
	assign hdr_ok = (q_pid == MTAL_PROTO_ID) && (q_unit == MTAL_UNIT_ID);
	assign is_multi = (q_func == MTAL_FC_READ) || (q_func == MTAL_FC_WRITEN);
	assign is_reg = is_multi || (q_func == MTAL_FC_WRITE1);
	assign unsup = !is_reg && (q_func != MTAL_FC_LOG);
	// one accessible register is enough to avoid an error
	assign addr_bad = is_reg && ((q_exist_cnt == 16'h0000) ||
		(q_ok_cnt == 16'h0000));
	// zero quantity or out-of-range / mode data
	assign data_bad = is_reg && (q_data_bad ||
		(is_multi && (q_qty == 16'h0000)));
	assign exc = unsup || drive_busy || addr_bad || data_bad;

	// exception code priority: function, busy, address, data
	always_comb begin
		if (unsup) begin
			exc_code = MTAL_EX_FUNC;
		end else if (drive_busy) begin
			exc_code = MTAL_EX_BUSY;
		end else if (addr_bad) begin
			exc_code = MTAL_EX_ADDR;
		end else begin
			exc_code = MTAL_EX_DATA;
		end
	end

	// ------------------------------------------------------------
	// access log
	// ------------------------------------------------------------
	// updated on every answered query; the H46 reply loads old values
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			log_start <= MTAL_LOG_RESET;
			log_count <= MTAL_LOG_RESET;
		end else if (take && hdr_ok) begin
			if (is_reg && !exc) begin
				log_start <= q_start;
				log_count <= q_ok_cnt;
			end else begin
				log_start <= MTAL_LOG_RESET;
				log_count <= MTAL_LOG_RESET;
			end
		end
	end

	// ------------------------------------------------------------
	// response state and serialiser
	// ------------------------------------------------------------
	// idle takes queries; send holds until the last byte leaves
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			state_q <= MTAL_IDLE;
			q_ready <= 1'b0;
		end else begin
			case (state_q)
				MTAL_IDLE: begin
					q_ready <= 1'b1;
					if (take && hdr_ok && (exc || !is_reg)) begin
						state_q <= MTAL_SEND;
						q_ready <= 1'b0;
					end
				end
				MTAL_SEND: begin
					if (tx_valid && tx_ready && tx_last) begin
						state_q <= MTAL_IDLE;
						q_ready <= 1'b1;
					end
				end
				default: begin
					state_q <= MTAL_IDLE;
					q_ready <= 1'b0;
				end
			endcase
		end
	end

	// frame built whole, shifted out high byte first
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			frame_q <= 96'h0;
			left_q <= 4'h0;
			tx_valid <= 1'b0;
			tx_last <= 1'b0;
		end else if (state_q == MTAL_IDLE) begin
			if (take && hdr_ok && exc) begin
				frame_q <= {q_tid, MTAL_PROTO_ID, MTAL_EXC_LEN,
					MTAL_UNIT_ID, q_func | MTAL_FC_EXC_FLAG,
					exc_code, MTAL_PAD};
				left_q <= MTAL_EXC_BYTES;
				tx_valid <= 1'b1;
				tx_last <= 1'b0;
			end else if (take && hdr_ok && !is_reg) begin
				frame_q <= {q_tid, MTAL_PROTO_ID, MTAL_LOG_LEN,
					MTAL_UNIT_ID, MTAL_FC_LOG, log_start,
					log_count};
				left_q <= MTAL_LOG_BYTES;
				tx_valid <= 1'b1;
				tx_last <= 1'b0;
			end
		end else if (tx_valid && tx_ready) begin
			frame_q <= {frame_q[87:0], 8'h00};
			left_q <= left_q - 4'h1;
			tx_valid <= !tx_last;
			tx_last <= (left_q == 4'h2);
		end
	end

	assign tx_data = frame_q[95:88];

	// normal register queries are answered by the register functions
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			fwd_valid <= 1'b0;
		end else begin
			fwd_valid <= take && hdr_ok && is_reg && !exc;
		end
	end

	// ------------------------------------------------------------
	// per-register gate inside a block access
	// ------------------------------------------------------------
	// missing registers read as zero and swallow written data
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			rd_valid <= 1'b0;
			rd_data <= 16'h0000;
			wr_en <= 1'b0;
			wr_data <= 16'h0000;
		end else begin
			rd_valid <= rd_req;
			rd_data <= rd_exist ? rd_word : 16'h0000;
			wr_en <= wr_req && wr_exist;
			wr_data <= wr_word;
		end
	end

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);

	// transaction id of the query being answered
	logic [15:0] tid_seen_q;
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			tid_seen_q <= 16'h0000;
		end else if (take) begin
			tid_seen_q <= q_tid;
		end
	end

	// queries with a nonzero protocol id reach neither the sink nor the register functions
	drop_pid_a: assert property (take && (q_pid != MTAL_PROTO_ID)
		|=> !tx_valid && !fwd_valid)
		else $error("reply sent for nonzero protocol id");
	// every reply carries protocol id zero and our unit id
	hdr_const_a: assert property ($rose(tx_valid)
		|-> (frame_q[79:64] == MTAL_PROTO_ID) &&
		(frame_q[47:40] == MTAL_UNIT_ID))
		else $error("reply header constants wrong");
	// first two bytes echo the taken id, high byte first
	tid_echo_a: assert property ($rose(tx_valid)
		|-> (tx_data == tid_seen_q[15:8]) ##1
		(tx_data == ($past(tx_ready) ? tid_seen_q[7:0] :
		tid_seen_q[15:8])))
		else $error("transaction id not echoed");
	// a stalled byte stands until the sink takes it
	hold_byte_a: assert property (tx_valid && !tx_ready
		|=> tx_valid && $stable(tx_data) && $stable(tx_last))
		else $error("response byte changed while stalled");
	// log reply carries the values from before this query
	log_reply_a: assert property (take && hdr_ok &&
		(q_func == MTAL_FC_LOG) && !drive_busy
		|=> frame_q[31:0] == {$past(log_start), $past(log_count)})
		else $error("log reply does not hold previous log");
	// any other function clears the log
	log_zero_a: assert property (take && hdr_ok && !is_reg
		|=> log_start == 16'h0000 && log_count == 16'h0000)
		else $error("log not cleared by other function");
	// a good register query becomes the new log entry
	log_keep_a: assert property (take && hdr_ok && is_reg && !exc
		|=> log_start == $past(q_start) && log_count == $past(q_ok_cnt))
		else $error("log not taken from register query");
	// exception frame: flagged function code and short length
	exc_func_a: assert property (take && hdr_ok && exc
		|=> frame_q[39:32] == ($past(q_func) | MTAL_FC_EXC_FLAG)
		&& frame_q[63:48] == MTAL_EXC_LEN)
		else $error("exception function code wrong");
	// busy ranks below an unsupported function only
	busy_code_a: assert property (take && hdr_ok && !unsup
		&& drive_busy |=> frame_q[31:24] == MTAL_EX_BUSY)
		else $error("busy code wrong");
	// one accessible register is enough for a block access
	partial_ok_a: assert property (take && hdr_ok && is_multi &&
		!drive_busy && !q_data_bad && (q_qty != 16'h0000) &&
		(q_exist_cnt != 16'h0000) && (q_ok_cnt != 16'h0000)
		|=> fwd_valid && !tx_valid)
		else $error("error on partly accessible access");
	// nothing addressed exists: exception instead of forwarding
	none_exist_a: assert property (take && hdr_ok && is_reg &&
		(q_exist_cnt == 16'h0000) |=> tx_valid && !fwd_valid)
		else $error("no exception for missing registers");
	// missing registers read as zero and drop writes
	rd_zero_a: assert property (rd_req && !rd_exist
		|=> rd_valid && rd_data == 16'h0000)
		else $error("missing register read nonzero");
	wr_drop_a: assert property (wr_req && !wr_exist |=> !wr_en)
		else $error("write to missing register passed");
	// exception frames leave as nine bytes
	exc_len_a: assert property ($rose(tx_valid) && frame_q[39]
		|-> (left_q == MTAL_EXC_BYTES))
		else $error("exception frame length wrong");

	// main scenarios: log reply, exception, forward, busy
	log_reply_c: cover property (take && hdr_ok && q_func == MTAL_FC_LOG
		##[1:20] tx_valid && tx_ready && tx_last);
	exc_reply_c: cover property (take && hdr_ok && exc && addr_bad);
	fwd_c: cover property (fwd_valid);
	busy_c: cover property (take && hdr_ok && drive_busy && !unsup);

endmodule : mtal_responder

// File: verification/mtal_sink.sv
/*
 * Response sink model standing in for the remote master.
 * Assumes one response byte per tx_valid/tx_ready handshake on clk.
 */
`timescale 1ns/1ps

module mtal_sink (
	input wire logic clk,
	input wire logic resetn,
	input wire logic slow,
	input wire logic tx_valid,
	input wire logic [7:0] tx_data,
	input wire logic tx_last,
	output logic tx_ready
);
	logic [7:0] got[$];
	logic done;

	initial begin
		tx_ready = 1'b0;
		done = 1'b0;
	end

	// collect bytes in wire order, stall every other cycle when slow
	always @(posedge clk) begin
		if (resetn && tx_valid && tx_ready) begin
			got.push_back(tx_data);
			if (tx_last) done <= 1'b1;
		end
		tx_ready <= #1 slow ? ~tx_ready : 1'b1;
	end
endmodule : mtal_sink

// File: verification/mtal_responder_tb.sv
/*
 * Self-checking bench for the access-log and exception responder.
 * Assumes the sink model drains responses; no other parties.
 */
`timescale 1ns/1ps

module mtal_responder_tb;
	import mtal_pkg::*;
	typedef logic [7:0] mtal_bq_t[$];
	logic clk, resetn, q_valid, q_ready, q_data_bad, drive_busy, fwd_valid;
	logic tx_valid, tx_ready, tx_last, rd_req, rd_exist, rd_valid;
	logic wr_req, wr_exist, wr_en, slow, fwd_seen;
	logic [7:0] q_unit, q_func, tx_data;
	logic [15:0] q_tid, q_pid, q_start, q_qty, q_exist_cnt, q_ok_cnt;
	logic [15:0] log_start, log_count, rd_word, rd_data, wr_word, wr_data;
	int bad_count = 0;
	int checks_done = 0;

	mtal_responder i_mtal_responder (.clk(clk), .resetn(resetn),
		.q_valid(q_valid), .q_ready(q_ready),
		.q_tid(q_tid), .q_pid(q_pid),
		.q_unit(q_unit), .q_func(q_func),
		.q_start(q_start), .q_qty(q_qty),
		.q_exist_cnt(q_exist_cnt), .q_ok_cnt(q_ok_cnt),
		.q_data_bad(q_data_bad), .drive_busy(drive_busy),
		.fwd_valid(fwd_valid), .tx_valid(tx_valid),
		.tx_ready(tx_ready), .tx_data(tx_data),
		.tx_last(tx_last), .log_start(log_start),
		.log_count(log_count), .rd_req(rd_req),
		.rd_exist(rd_exist), .rd_word(rd_word),
		.rd_valid(rd_valid), .rd_data(rd_data),
		.wr_req(wr_req), .wr_exist(wr_exist),
		.wr_word(wr_word), .wr_en(wr_en), .wr_data(wr_data));
	mtal_sink i_mtal_sink (.clk(clk), .resetn(resetn), .slow(slow),
		.tx_valid(tx_valid), .tx_data(tx_data), .tx_last(tx_last),
		.tx_ready(tx_ready));

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	task automatic cmp(input logic [15:0] g, input logic [15:0] e);
		checks_done++;
		if (g !== e) begin
			bad_count++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask : cmp

	task automatic wrap_up();
		$display("checks=%0d mismatches=%0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask : wrap_up

	// one query, header fields as given by the caller, held until taken
	task automatic send(input logic [15:0] tid, pid, input logic [7:0] un, fn,
		input logic [15:0] st, qty, ex, ok, input logic bd, bz);
		@(posedge clk) #1;
		while (q_ready !== 1'b1) @(posedge clk) #1;
		i_mtal_sink.got.delete();
		i_mtal_sink.done = 1'b0;
		q_valid = 1'b1;
		{q_tid, q_pid, q_unit, q_func} = {tid, pid, un, fn};
		{q_start, q_qty, q_exist_cnt, q_ok_cnt} = {st, qty, ex, ok};
		{q_data_bad, drive_busy} = {bd, bz};
		@(posedge clk) #1;
		// fwd_valid stands only in the cycle after the take
		fwd_seen = fwd_valid;
		q_valid = 1'b0;
	endtask : send

	task automatic chk_frame(input mtal_bq_t e);
		int n;
		n = 0;
		while (i_mtal_sink.done !== 1'b1 && n < 300) begin
			@(posedge clk) #1;
			n++;
		end
		cmp({15'h0000, i_mtal_sink.done}, 16'h0001);
		cmp(16'(i_mtal_sink.got.size()), 16'(e.size()));
		foreach (e[i]) cmp({8'h00, i_mtal_sink.got[i]}, {8'h00, e[i]});
	endtask : chk_frame

	// query the log and judge the whole reply frame
	task automatic ask_log(input logic [15:0] tid, s, c);
		send(tid, 16'h0000, 8'hFF, 8'h46, 16'h0000, 16'h0000, 16'h0000,
			16'h0000, 1'b0, 1'b0);
		chk_frame('{tid[15:8], tid[7:0], 8'h00, 8'h00, 8'h00, 8'h06, 8'hFF,
			8'h46, s[15:8], s[7:0], c[15:8], c[7:0]});
	endtask : ask_log

	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	task automatic t_log();
		logic [7:0] fns[3] = '{8'h03, 8'h06, 8'h10};
		cmp(log_start, 16'h0000);
		ask_log(16'h1234, 16'h0000, 16'h0000);
		foreach (fns[i]) begin
			slow = i[0];
			send(16'h0040, 16'h0000, 8'hFF, fns[i], 16'h03EE + 16'(i),
				16'h0003, 16'h0002, 16'h0001, 1'b0, 1'b0);
			cmp({15'h0000, fwd_seen}, 16'h0001);
			cmp(log_count, 16'h0001);
			ask_log(16'hA55A, 16'h03EE + 16'(i), 16'h0001);
		end
		ask_log(16'h0BEE, 16'h0000, 16'h0000);
		slow = 1'b0;
		$display("test log done");
	endtask : t_log

	task automatic t_exc();
		logic [7:0] fn[7] = '{8'h05, 8'h03, 8'h46, 8'h03, 8'h10, 8'h06, 8'h10};
		logic [7:0] cd[7] = '{8'h01, 8'h06, 8'h06, 8'h02, 8'h02, 8'h03, 8'h03};
		logic [4:0] fl[7] = '{5'h00, 5'h02, 5'h02, 5'h18, 5'h08, 5'h04, 5'h01};
		foreach (fn[i]) begin
			send(16'h7E00 + 16'(i), 16'h0000, 8'hFF, fn[i], 16'h0010,
				{15'h0000, ~fl[i][0]}, fl[i][4] ? 16'h0000 : 16'h0002,
				fl[i][3] ? 16'h0000 : 16'h0001, fl[i][2], fl[i][1]);
			cmp({15'h0000, fwd_seen}, 16'h0000);
			cmp({14'h0000, q_ready, tx_valid}, 16'h0001);
			chk_frame('{8'h7E, 8'(i), 8'h00, 8'h00, 8'h00, 8'h03, 8'hFF,
				fn[i] | 8'h80, cd[i]});
		end
		ask_log(16'h0001, 16'h0000, 16'h0000);
		$display("test exceptions done");
	endtask : t_exc

	task automatic t_drop();
		send(16'h0002, 16'h0000, 8'hFF, 8'h03, 16'h0005, 16'h0001,
			16'h0001, 16'h0001, 1'b0, 1'b0);
		send(16'h0003, 16'h0001, 8'hFF, 8'h46, 16'h0000, 16'h0000,
			16'h0000, 16'h0000, 1'b0, 1'b0);
		cmp({14'h0000, tx_valid, fwd_seen}, 16'h0000);
		send(16'h0004, 16'h0000, 8'h00, 8'h03, 16'h0009, 16'h0001,
			16'h0001, 16'h0001, 1'b0, 1'b0);
		repeat (5) @(posedge clk);
		cmp(16'(i_mtal_sink.got.size()), 16'h0000);
		cmp({15'h0000, fwd_seen}, 16'h0000);
		ask_log(16'h0005, 16'h0005, 16'h0001);
		$display("test drop done");
	endtask : t_drop

	task automatic t_gate();
		{rd_req, rd_exist, rd_word, wr_req, wr_exist} = {2'b10, 16'hABCD, 2'b11};
		wr_word = 16'h1357;
		@(posedge clk) #1;
		cmp({rd_valid, wr_en, 14'h0000}, 16'hC000);
		cmp(rd_data, 16'h0000);
		cmp(wr_data, 16'h1357);
		{rd_exist, wr_exist} = 2'b10;
		@(posedge clk) #1;
		{rd_req, wr_req} = 2'b00;
		cmp(rd_data, 16'hABCD);
		cmp({15'h0000, wr_en}, 16'h0000);
		@(posedge clk) #1;
		cmp({rd_valid, wr_en, 14'h0000}, 16'h0000);
		$display("test gate done");
	endtask : t_gate

	initial begin
		{resetn, q_valid, q_data_bad, drive_busy, slow} = 5'h00;
		{q_unit, q_func, q_tid, q_pid, q_start, q_qty} = 80'h0;
		{q_exist_cnt, q_ok_cnt, rd_word, wr_word} = 64'h0;
		{rd_req, rd_exist, wr_req, wr_exist} = 4'h0;
		repeat (8) @(posedge clk);
		#1 resetn = 1'b1;
		t_log();
		t_exc();
		t_drop();
		t_gate();
		wrap_up();
	end

	// watchdog well beyond the expected run
	initial begin
		#200000;
		bad_count++;
		wrap_up();
	end
endmodule : mtal_responder_tb
